//--- common/tccb_pkg.sv
// Shared constants of the compare and capture register block
package tccb_pkg;
    localparam int NUM_CH = 5;
    localparam int REG_W = 16;
    localparam int NUM_BUF = 4;
    localparam int BUF_FIRST_CH = 3;
    localparam int IOC_W = 8;
    localparam int ADDR_W = 4;
    localparam logic [15:0] GR_RESET = 16'hffff;
    localparam logic [15:0] BUF_RESET = 16'hffff;
    localparam logic [15:0] RDATA_RESET = 16'h0000;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic PIN_RESET = 1'b0;
    // General register index is ch*2 + (B ? 1 : 0)
    localparam logic [3:0] OFS_GR_BASE = 4'h0;
    // Buffer index is (ch-3)*2 + (B ? 1 : 0)
    localparam logic [3:0] OFS_BUF_BASE = 4'ha;
    localparam int IOC_A_LSB = 0;
    localparam int IOC_B_LSB = 4;
    localparam int IOC_CAP_BIT = 2;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam int EDGE_BOTH_BIT = 1;
    localparam int EDGE_FALL_BIT = 0;
    localparam logic [1:0] CLR_A = 2'h1;
    localparam logic [1:0] CLR_B = 2'h2;
endpackage

//--- common/tccb_evt_if.sv
// Event signals between the register core, comparators and edge detectors
`timescale 1ns/1ps
interface tccb_evt_if #(parameter int N = 10);
    logic [N*16-1:0] gr_value;
    logic [N*16-1:0] cnt_value;
    logic [N-1:0] cmp_mode;
    logic [N-1:0] cap_mode;
    logic [2*N-1:0] edge_sel;
    logic [N-1:0] cap_pin;
    logic [N-1:0] match_pulse;
    logic [N-1:0] capture_pulse;
    modport core (output gr_value, cnt_value, cmp_mode, cap_mode, edge_sel, cap_pin,
        input match_pulse, capture_pulse);
    modport cmp (input gr_value, cnt_value, cmp_mode, output match_pulse);
    modport capt (input cap_mode, edge_sel, cap_pin, output capture_pulse);
endinterface

//--- rtl/tccb_compare.sv
// Compare match detectors, one per general register
`timescale 1ns/1ps
module tccb_compare #(
    parameter int N = 10
) (
    input wire logic clock,
    input wire logic init,
    tccb_evt_if.cmp ev
);
    logic [N-1:0] eq;
    logic [N-1:0] eq_prev_r;

    for (genvar i = 0; i < N; i++)
    begin : g_eq
        assign eq[i] = ev.gr_value[16*i +: 16] == ev.cnt_value[16*i +: 16];
        // One pulse per match, since a prescaled counter may hold its value
        assign ev.match_pulse[i] = ev.cmp_mode[i] & eq[i] & ~eq_prev_r[i];
    end

    always_ff @(posedge clock)
    begin
        if (init)
            eq_prev_r <= '0;
        else
            eq_prev_r <= eq;
    end

    chk_match_single: assert property (@(posedge clock) disable iff (init)
        ev.match_pulse[0] |=> !ev.match_pulse[0])
        else $error("match pulse lasted two cycles");
    chk_match_cause: assert property (@(posedge clock) disable iff (init)
        ev.match_pulse[6] |-> ev.cmp_mode[6] && eq[6] && !$past(eq[6]))
        else $error("match pulse without a new match in compare role");
endmodule

//--- rtl/tccb_edge_detect.sv
// Capture edge detectors, one per general register
`timescale 1ns/1ps
module tccb_edge_detect #(
    parameter int N = 10
) (
    input wire logic clock,
    input wire logic init,
    tccb_evt_if.capt ev
);
    logic [N-1:0] prev_r;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [N-1:0] hit;
    // Holds off the first cycle so a pin already high is not taken as an edge
    logic armed_r;

    for (genvar i = 0; i < N; i++)
    begin : g_edge
        assign rise[i] = ev.cap_pin[i] & ~prev_r[i];
        assign fall[i] = ~ev.cap_pin[i] & prev_r[i];
        assign hit[i] = ev.edge_sel[2*i + tccb_pkg::EDGE_BOTH_BIT] ? (rise[i] | fall[i]) :
            (ev.edge_sel[2*i + tccb_pkg::EDGE_FALL_BIT] ? fall[i] : rise[i]);
        assign ev.capture_pulse[i] = armed_r & ev.cap_mode[i] & hit[i];
    end

    always_ff @(posedge clock)
    begin
        if (init)
            prev_r <= '0;
        else
            prev_r <= ev.cap_pin;
    end

    always_ff @(posedge clock)
    begin
        if (init)
            armed_r <= 1'b0;
        else
            armed_r <= 1'b1;
    end

    chk_edge_fall: assert property (@(posedge clock) disable iff (init)
        armed_r && ev.cap_mode[8] && ev.edge_sel[17:16] == 2'h1 && $fell(ev.cap_pin[8])
        |-> ev.capture_pulse[8])
        else $error("falling edge not captured");
    chk_edge_role: assert property (@(posedge clock) disable iff (init)
        !ev.cap_mode[2] |-> !ev.capture_pulse[2])
        else $error("capture in compare role");
endmodule

//--- rtl/tccb_top.sv
// Compare/capture general registers and buffer registers of a five-channel timer
`timescale 1ns/1ps
module tccb_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic standby,
    input wire logic [tccb_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [1:0] bus_be,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    input wire logic [tccb_pkg::NUM_CH*16-1:0] channel_counter,
    input wire logic [tccb_pkg::NUM_CH*tccb_pkg::IOC_W-1:0] io_control_register,
    input wire logic [tccb_pkg::NUM_CH-1:0] pwm_mode,
    input wire logic [tccb_pkg::NUM_BUF-1:0] buffer_enable,
    input wire logic [2*tccb_pkg::NUM_CH-1:0] counter_clear_select,
    input wire logic [2*tccb_pkg::NUM_CH-1:0] capture_in,
    input wire logic [2*tccb_pkg::NUM_CH-1:0] flag_clear,
    output logic [2*tccb_pkg::NUM_CH-1:0] match_capture_flag,
    output logic [2*tccb_pkg::NUM_CH-1:0] compare_pin_out,
    output logic [2*tccb_pkg::NUM_CH-1:0] compare_pin_oe,
    output logic [tccb_pkg::NUM_CH-1:0] counter_clear
);
    localparam int NCH = tccb_pkg::NUM_CH;
    localparam int NGR = 2 * tccb_pkg::NUM_CH;
    localparam int NBUF = tccb_pkg::NUM_BUF;
    localparam int AW = tccb_pkg::ADDR_W;
    localparam int BUF_GR0 = 2 * tccb_pkg::BUF_FIRST_CH;

    logic init;
    logic [15:0] gr_r [NGR];
    logic [15:0] br_r [NBUF];
    logic [15:0] buf_src [NGR];
    logic [NGR-1:0] buf_on;
    logic [NGR-1:0] gr_wr_hit;
    logic [NBUF-1:0] br_wr_hit;
    logic [1:0] action [NGR];
    logic [NGR-1:0] event_any;
    logic [NGR-1:0] flag_r;
    logic [NGR-1:0] pin_r;
    logic [15:0] rdata_r;

    tccb_evt_if #(.N(NGR)) ev ();

    // Standby clears everything exactly as reset does
    assign init = rst | standby;

    for (genvar i = 0; i < NGR; i++)
    begin : g_gr
        localparam int CH = i / 2;
        localparam int LSB = (i % 2 == 0) ? tccb_pkg::IOC_A_LSB : tccb_pkg::IOC_B_LSB;
        logic [2:0] sel;
        // PWM modes own the pins, so the register falls back to plain compare
        assign sel = pwm_mode[CH] ? 3'h0 :
            io_control_register[CH*tccb_pkg::IOC_W + LSB +: 3];
        assign ev.cmp_mode[i] = ~sel[tccb_pkg::IOC_CAP_BIT];
        assign ev.cap_mode[i] = sel[tccb_pkg::IOC_CAP_BIT];
        assign ev.edge_sel[2*i +: 2] = sel[1:0];
        assign action[i] = sel[1:0];
        assign ev.gr_value[16*i +: 16] = gr_r[i];
        assign ev.cnt_value[16*i +: 16] = channel_counter[16*CH +: 16];
        assign ev.cap_pin[i] = capture_in[i];
        assign gr_wr_hit[i] = bus_wr && (bus_addr == tccb_pkg::OFS_GR_BASE + AW'(i));
        assign event_any[i] = ev.match_pulse[i] | ev.capture_pulse[i];
        assign compare_pin_oe[i] = ev.cmp_mode[i] && (action[i] != tccb_pkg::ACT_NONE);
        if (i >= BUF_GR0 && i < BUF_GR0 + NBUF)
        begin : g_buf
            assign buf_on[i] = buffer_enable[i - BUF_GR0];
            assign buf_src[i] = br_r[i - BUF_GR0];
        end
        else
        begin : g_nobuf
            assign buf_on[i] = 1'b0;
            assign buf_src[i] = tccb_pkg::BUF_RESET;
        end
    end

    for (genvar b = 0; b < NBUF; b++)
    begin : g_br_hit
        assign br_wr_hit[b] = bus_wr && (bus_addr == tccb_pkg::OFS_BUF_BASE + AW'(b));
    end

    for (genvar c = 0; c < NCH; c++)
    begin : g_clr
        assign counter_clear[c] =
            (counter_clear_select[2*c +: 2] == tccb_pkg::CLR_A && event_any[2*c]) ||
            (counter_clear_select[2*c +: 2] == tccb_pkg::CLR_B && event_any[2*c+1]);
    end

    tccb_compare #(.N(NGR)) u_compare (
        .clock(clock),
        .init(init),
        .ev(ev.cmp)
    );

    tccb_edge_detect #(.N(NGR)) u_edge (
        .clock(clock),
        .init(init),
        .ev(ev.capt)
    );

    // A CPU write in the same cycle as an event wins the written byte lanes
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < NGR; i++)
        begin
            if (init)
                gr_r[i] <= tccb_pkg::GR_RESET;
            else
            begin
                if (ev.capture_pulse[i])
                    gr_r[i] <= channel_counter[16*(i/2) +: 16];
                else if (ev.match_pulse[i] && buf_on[i])
                    gr_r[i] <= buf_src[i];
                if (gr_wr_hit[i] && bus_be[0])
                    gr_r[i][7:0] <= bus_wdata[7:0];
                if (gr_wr_hit[i] && bus_be[1])
                    gr_r[i][15:8] <= bus_wdata[15:8];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        for (int b = 0; b < NBUF; b++)
        begin
            if (init)
                br_r[b] <= tccb_pkg::BUF_RESET;
            else
            begin
                if (ev.capture_pulse[BUF_GR0+b] && buf_on[BUF_GR0+b])
                    br_r[b] <= gr_r[BUF_GR0+b];
                if (br_wr_hit[b] && bus_be[0])
                    br_r[b][7:0] <= bus_wdata[7:0];
                if (br_wr_hit[b] && bus_be[1])
                    br_r[b][15:8] <= bus_wdata[15:8];
            end
        end
    end

    // A new event wins over a clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (init)
            flag_r <= {NGR{tccb_pkg::FLAG_RESET}};
        else
            flag_r <= (flag_r & ~flag_clear) | event_any;
    end

    always_ff @(posedge clock)
    begin
        for (int i = 0; i < NGR; i++)
        begin
            if (init)
                pin_r[i] <= tccb_pkg::PIN_RESET;
            else if (ev.match_pulse[i])
            begin
                case (action[i])
                    tccb_pkg::ACT_LOW: pin_r[i] <= 1'b0;
                    tccb_pkg::ACT_HIGH: pin_r[i] <= 1'b1;
                    tccb_pkg::ACT_TOGGLE: pin_r[i] <= ~pin_r[i];
                    default: pin_r[i] <= pin_r[i];
                endcase
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (init)
            rdata_r <= tccb_pkg::RDATA_RESET;
        else if (bus_rd)
        begin
            if (bus_addr < tccb_pkg::OFS_GR_BASE + AW'(NGR))
                rdata_r <= gr_r[bus_addr];
            else if (bus_addr >= tccb_pkg::OFS_BUF_BASE &&
                     bus_addr < tccb_pkg::OFS_BUF_BASE + AW'(NBUF))
                rdata_r <= br_r[2'(bus_addr - tccb_pkg::OFS_BUF_BASE)];
            else
                rdata_r <= tccb_pkg::RDATA_RESET;
        end
    end

    assign bus_rdata = rdata_r;
    assign match_capture_flag = flag_r;
    assign compare_pin_out = pin_r;

    default clocking dflt @(posedge clock);
    endclocking
    default disable iff (init);

    chk_gr_reset: assert property (@(posedge clock) disable iff (1'b0)
        init |=> gr_r[0] == 16'hffff && gr_r[9] == 16'hffff && !compare_pin_oe[0])
        else $error("general register not all ones after reset");
    chk_buf_reset: assert property (@(posedge clock) disable iff (1'b0)
        init |=> br_r[0] == 16'hffff && br_r[3] == 16'hffff)
        else $error("buffer register not all ones after reset");
    chk_cmp_flag: assert property (
        ev.match_pulse[0] |=> match_capture_flag[0] [*2])
        else $error("match flag not set and held");
    chk_cap_latch: assert property (
        ev.capture_pulse[8] && !gr_wr_hit[8]
        |=> gr_r[8] == $past(channel_counter[79:64]) && match_capture_flag[8])
        else $error("capture did not latch counter");
    chk_buf_load: assert property (
        ev.match_pulse[6] && buf_on[6] && !gr_wr_hit[6] |=> gr_r[6] == $past(br_r[0]))
        else $error("buffer not copied at compare match");
    chk_buf_capture: assert property (
        ev.capture_pulse[8] && buf_on[8] && !br_wr_hit[2]
        |=> br_r[2] == $past(gr_r[8]))
        else $error("old general value not moved to buffer");
    chk_byte_write: assert property (
        bus_wr && bus_addr == 4'h0 && bus_be == 2'h1 && !event_any[0]
        |=> gr_r[0][15:8] == $past(gr_r[0][15:8]) && gr_r[0][7:0] == $past(bus_wdata[7:0]))
        else $error("byte write disturbed the other byte");
    chk_pwm_ignore: assert property (
        pwm_mode[0] |-> !compare_pin_oe[0] && !ev.capture_pulse[1])
        else $error("io control honoured in PWM mode");
    chk_clear_a: assert property (
        counter_clear_select[1:0] == 2'h1 && event_any[0] |-> counter_clear[0])
        else $error("counter clear missing on A event");
    chk_role_excl: assert property (
        (ev.match_pulse & ev.capture_pulse) == '0)
        else $error("match and capture on one register");
    chk_toggle: assert property (
        ev.match_pulse[2] && action[2] == 2'h3 |=> compare_pin_out[2] != $past(pin_r[2]))
        else $error("toggle action failed");
    chk_flag_set_wins: assert property (
        event_any[3] && flag_clear[3] |=> match_capture_flag[3])
        else $error("clear beat a new event");

    // Bus, flag, pin and counter clear checks on register 0, the buffered channels and unmapped reads
    chk_rd_general: assert property (
        bus_rd && bus_addr == 4'h6 |=> bus_rdata == $past(gr_r[6]))
        else $error("general register read returned a wrong value");
    chk_rd_buffer: assert property (
        bus_rd && bus_addr == 4'hc |=> bus_rdata == $past(br_r[2]))
        else $error("buffer register read returned a wrong value");
    chk_rd_unmapped: assert property (
        bus_rd && bus_addr > 4'hd |=> bus_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_word_write: assert property (
        bus_wr && bus_addr == 4'ha && bus_be == 2'h3 && !ev.capture_pulse[6]
        |=> br_r[0] == $past(bus_wdata))
        else $error("word write to buffer lost");
    chk_high_byte: assert property (
        bus_wr && bus_addr == 4'hc && bus_be == 2'h2 && !ev.capture_pulse[8]
        |=> br_r[2][7:0] == $past(br_r[2][7:0]) && br_r[2][15:8] == $past(bus_wdata[15:8]))
        else $error("high byte write disturbed the low byte");
    chk_pin_high: assert property (
        ev.match_pulse[0] && action[0] == tccb_pkg::ACT_HIGH |=> compare_pin_out[0])
        else $error("high action did not drive the pin");
    chk_flag_sticky: assert property (
        match_capture_flag[0] && !flag_clear[0] |=> match_capture_flag[0])
        else $error("flag dropped without a clear");
    chk_flag_clear: assert property (
        flag_clear[0] && !event_any[0] |=> !match_capture_flag[0])
        else $error("flag not cleared");
    chk_no_buffer: assert property (
        ev.match_pulse[0] && !gr_wr_hit[0] |=> gr_r[0] == $past(gr_r[0]))
        else $error("unbuffered register changed at compare match");
    chk_clear_none: assert property (
        counter_clear_select[1:0] == 2'h0 |-> !counter_clear[0])
        else $error("counter clear without selection");
    chk_pin_reset: assert property (@(posedge clock) disable iff (1'b0)
        init |=> !compare_pin_out[0] && !match_capture_flag[0])
        else $error("pin or flag not cleared by reset");
    chk_oe_none: assert property (
        !pwm_mode[0] && io_control_register[2:0] == 3'h0 |-> !compare_pin_oe[0])
        else $error("pin driven with no action selected");
    chk_oe_action: assert property (
        !pwm_mode[0] && io_control_register[2:0] == 3'h2 |-> compare_pin_oe[0])
        else $error("pin not driven with an action selected");

    cov_capture: cover property (ev.capture_pulse[8] ##1 match_capture_flag[8]);
    cov_buf_cmp: cover property (ev.match_pulse[6] && buf_on[6]);
    cov_buf_cap: cover property (ev.capture_pulse[8] && buf_on[8]);
    cov_both_edge: cover property (ev.capture_pulse[8] && ev.edge_sel[17]);
    cov_toggle: cover property (ev.match_pulse[2] && action[2] == tccb_pkg::ACT_TOGGLE);
endmodule

//--- verification/tccb_capture_src.sv
// Far-side model of the external capture input pins
`timescale 1ns/1ps
module tccb_capture_src (
    input wire logic clock,
    input wire logic [9:0] level_req,
    output logic [9:0] pins
);
    // Pins move only at clock edges, like a source already synchronised
    initial pins = 10'h000;
    always @(posedge clock)
    begin
        pins <= level_req;
    end
endmodule

//--- verification/timer_compare_capture_buffers_tb.sv
// Self-checking bench of the compare and capture register block
`timescale 1ns/1ps
module timer_compare_capture_buffers_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic standby = 1'b0;
    logic [3:0] bus_addr = 4'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [1:0] bus_be = 2'h3;
    logic [15:0] bus_wdata = 16'h0000;
    logic [15:0] bus_rdata;
    logic [79:0] cnt = '0;
    logic [39:0] ioc = '0;
    logic [4:0] pwm = 5'h00;
    logic [3:0] bufen = 4'h0;
    logic [9:0] clrsel = 10'h000;
    logic [9:0] pin_req = 10'h000;
    logic [9:0] cap_pins;
    logic [9:0] fclr = 10'h000;
    logic [9:0] flag;
    logic [9:0] pin_out;
    logic [9:0] pin_oe;
    logic [4:0] cclr;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int mdl[16];
    logic [31:0] seed = 32'h0000_0907;

    tccb_top u_tccb_top (.clock(clock), .rst(rst), .standby(standby), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .channel_counter(cnt), .io_control_register(ioc),
        .pwm_mode(pwm), .buffer_enable(bufen), .counter_clear_select(clrsel),
        .capture_in(cap_pins), .flag_clear(fclr), .match_capture_flag(flag),
        .compare_pin_out(pin_out), .compare_pin_oe(pin_oe), .counter_clear(cclr));
    tccb_capture_src u_tccb_capture_src (.clock(clock), .level_req(pin_req), .pins(cap_pins));

    always #5 clock = ~clock;

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction

    task automatic mdl_reset();
        for (int a = 0; a < 16; a++)
            mdl[a] = (a < 14) ? 32'h0000_ffff : 32'h0000_0000;
    endtask

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Counts: comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Unmapped indexes are dropped by the model as the design drops them
    task automatic wr(int a, logic [15:0] d, logic [1:0] be);
        @(posedge clock);
        bus_addr <= 4'(a);
        bus_wr <= 1'b1;
        bus_be <= be;
        bus_wdata <= d;
        @(posedge clock);
        bus_wr <= 1'b0;
        if (a < 14 && be[0])
            mdl[a] = {mdl[a][15:8], d[7:0]};
        if (a < 14 && be[1])
            mdl[a] = {d[15:8], mdl[a][7:0]};
    endtask

    task automatic rd(int a);
        @(posedge clock);
        bus_addr <= 4'(a);
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        @(posedge clock);
        #1 check("bus_rdata", bus_rdata, mdl[a][15:0]);
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            finish_test();
        end
    end

    initial
    begin
        mdl_reset();
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++)
            rd(a);
        check("flags", {6'h00, flag}, 16'h0000);
        check("pin_oe", {6'h00, pin_oe}, 16'h0000);
        $display("Test reset values done");
        for (int a = 0; a < 15; a++)
        begin
            wr(a, rnd(), 2'h3);
            wr(a, rnd(), 2'h1);
            wr(a, rnd(), 2'h2);
            rd(a);
        end
        $display("Test register access done");
        wr(0, 16'h0040, 2'h3);
        @(posedge clock);
        fclr <= 10'h3ff;
        @(posedge clock);
        fclr <= 10'h000;
        ioc[7:0] <= 8'h02;
        clrsel[1:0] <= 2'h1;
        cnt[15:0] <= 16'h0040;
        #1 check("counter_clear", {15'h0000, cclr[0]}, 16'h0001);
        @(posedge clock);
        #1 check("flag", {15'h0000, flag[0]}, 16'h0001);
        check("pin_out", {15'h0000, pin_out[0]}, 16'h0001);
        check("pin_oe", {15'h0000, pin_oe[0]}, 16'h0001);
        wr(6, 16'h0050, 2'h3);
        @(posedge clock);
        bufen <= 4'h1;
        cnt[63:48] <= 16'h0050;
        repeat (2) @(posedge clock);
        mdl[6] = mdl[10];
        rd(6);
        $display("Test compare done");
        for (int e = 0; e < 3; e++)
        begin
            // Counter moved off the old capture so the compare role never fires here
            @(posedge clock);
            ioc[39:32] <= 8'h00;
            cnt[79:64] <= 16'h0000;
            bufen <= 4'h4;
            fclr <= 10'h3ff;
            pin_req[8] <= (e == 1);
            @(posedge clock);
            fclr <= 10'h000;
            repeat (2) @(posedge clock);
            ioc[39:32] <= 8'(4 + e);
            cnt[79:64] <= 16'h0100 + 16'(e);
            repeat (2) @(posedge clock);
            pin_req[8] <= (e != 1);
            repeat (3) @(posedge clock);
            mdl[12] = mdl[8];
            mdl[8] = 32'h0000_0100 + e;
            rd(8);
            rd(12);
            check("flag", {15'h0000, flag[8]}, 16'h0001);
        end
        $display("Test capture done");
        wr(2, 16'h0200, 2'h3);
        wr(3, 16'h0200, 2'h3);
        @(posedge clock);
        ioc[15:8] <= 8'h03;
        fclr <= 10'h008;
        cnt[31:16] <= 16'h0200;
        @(posedge clock);
        fclr <= 10'h000;
        cnt[31:16] <= 16'h0000;
        #1 check("flag", {15'h0000, flag[3]}, 16'h0001);
        check("pin_out", {15'h0000, pin_out[2]}, 16'h0001);
        @(posedge clock);
        cnt[31:16] <= 16'h0200;
        @(posedge clock);
        #1 check("pin_out", {15'h0000, pin_out[2]}, 16'h0000);
        $display("Test toggle and flag priority done");
        @(posedge clock);
        pwm[0] <= 1'b1;
        #1 check("pin_oe", {15'h0000, pin_oe[0]}, 16'h0000);
        @(posedge clock);
        standby <= 1'b1;
        @(posedge clock);
        standby <= 1'b0;
        mdl_reset();
        rd(8);
        rd(12);
        $display("Test standby done");
        finish_test();
    end
endmodule
